// file: logic/pae_pkg.sv
// Purpose: Shared constants for the process alarm evaluator.
// Assumes: Signed 16-bit process quantities, AXI4-Lite register access.
// Notes: Offsets are byte addresses of 32-bit words.
package pae_pkg;
  localparam int PAE_VAL_W = 16;
  localparam int PAE_ADDR_W = 6;
  typedef logic signed [PAE_VAL_W-1:0] pae_val_t;
  typedef logic [PAE_ADDR_W-1:0] pae_addr_t;

  localparam pae_addr_t PAE_CTRL_OFS = 6'h00;
  localparam pae_addr_t PAE_HIGH_OFS = 6'h04;
  localparam pae_addr_t PAE_LOW_OFS = 6'h08;
  localparam pae_addr_t PAE_HYST_OFS = 6'h0C;
  localparam pae_addr_t PAE_SENS_HI_OFS = 6'h10;
  localparam pae_addr_t PAE_SENS_LO_OFS = 6'h14;
  localparam pae_addr_t PAE_STATE_OFS = 6'h18;
  localparam pae_addr_t PAE_ACTION_OFS = 6'h1C;
  localparam pae_addr_t PAE_IRQ_STAT_OFS = 6'h20;
  localparam pae_addr_t PAE_IRQ_MASK_OFS = 6'h24;

  // Control register fields.
  localparam int PAE_CTRL_TYPE_BIT = 0;
  localparam int PAE_CTRL_LATCH_BIT = 1;
  localparam int PAE_CTRL_SIL_BIT = 2;
  localparam int PAE_CTRL_BLOCK_BIT = 3;
  localparam int PAE_CTRL_HI_EN_BIT = 4;
  localparam int PAE_CTRL_LO_EN_BIT = 5;
  localparam int PAE_CTRL_W = 6;
  localparam logic [PAE_CTRL_W-1:0] PAE_CTRL_RST = 6'h30;

  // Action register fields (write-only pulses).
  localparam int PAE_ACT_CLEAR_BIT = 0;
  localparam int PAE_ACT_SILENCE_BIT = 1;

  // Interrupt status fields.
  localparam int PAE_IRQ_W = 4;
  localparam int PAE_IRQ_RAISE_BIT = 0;
  localparam int PAE_IRQ_END_BIT = 1;
  localparam int PAE_IRQ_CFG_BIT = 2;
  localparam int PAE_IRQ_ARM_BIT = 3;

  localparam pae_val_t PAE_HIGH_RST = 16'h0064;
  localparam pae_val_t PAE_LOW_RST = 16'h0000;
  localparam pae_val_t PAE_HYST_RST = 16'h0001;
  localparam pae_val_t PAE_SENS_HI_RST = 16'h7FFF;
  localparam pae_val_t PAE_SENS_LO_RST = 16'h8000;

  localparam logic [1:0] PAE_RESP_OKAY = 2'h0;
  localparam logic [1:0] PAE_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    PAE_ST_IDLE = 2'b00,
    PAE_ST_ALARM = 2'b01,
    PAE_ST_HELD = 2'b10
  } pae_state_e;
endpackage

// file: logic/pae_process_alarm_evaluator.sv
// Purpose: Alarm evaluator comparing a process value with high and low thresholds.
// Assumes: pv_valid pulses once per process value update; inputs synchronous to clk.
// Notes: Registers over AXI4-Lite; alarm state readable and clearable there.
// How it works
// [R1] Alarm asserts when the monitored value leaves the threshold-bounded range.
// [R2] Absolute type compares the value with fixed configured thresholds.
// [R3] Deviation type uses set point plus offset and set point minus offset.
// [R4] Deviation thresholds follow every set point change.
// [R5] High above low, both inside the sensor range; violations are flagged.
// [R6] Alarm enters once the value reaches either threshold.
// [R7] Clearing band lies hysteresis inside each threshold.
// [R8] Condition ends only after the value passes back beyond the band.
// [R9] Latching keeps the alarm after the condition ends until operator clear; here a clear in the same cycle as pv_valid is ignored.
// [R10] Without latching the alarm drops by itself when the condition ends.
// [R11] Silence during an alarm forces the output off while alarm persists.
// [R12] Output re-arms only once the value is back beyond the band.
// [R13] Blocking suppresses an alarm already present at startup.
// [R14] Under blocking detection starts after the value first enters normal range.
// [R15] Deviation blocking also re-blocks after every set point change.
// [R16] Alarm state is kept and clearable even with no output assigned.
// [R17] Active alarm alternates upper display and lights the attention indicator.
// [R18] Conditions are evaluated once per value update with current thresholds.
`timescale 1ns/1ps
`default_nettype none
module pae_process_alarm_evaluator
  import pae_pkg::*;
(
  input wire logic clk, // System clock, 20 MHz.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire pae_pkg::pae_val_t process_value, // Measured process value.
  input wire logic pv_valid, // Process value update strobe.
  input wire pae_pkg::pae_val_t control_setpoint, // Control set point.
  input wire logic op_clear, // Operator clear pulse from the panel.
  input wire logic op_silence, // Operator silence pulse from the panel.
  input wire logic display_tick, // Display toggle rate pulse.
  input wire pae_pkg::pae_addr_t s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire pae_pkg::pae_addr_t s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  output logic alarm_active, // Alarm state.
  output logic alarm_output, // Alarm output drive.
  output logic upper_show_message, // Upper display shows the message.
  output logic attention_indicator, // Lower display attention indication.
  output logic irq // Level interrupt.
);
  import pae_pkg::*;

  logic [PAE_CTRL_W-1:0] ctrl_r;
  pae_val_t high_alarm_setpoint_r;
  pae_val_t low_alarm_setpoint_r;
  pae_val_t hyst_r;
  pae_val_t sens_hi_r;
  pae_val_t sens_lo_r;
  logic [PAE_IRQ_W-1:0] irq_stat_r;
  logic [PAE_IRQ_W-1:0] irq_mask_r;
  pae_state_e state_r;
  logic silenced_r;
  logic blocked_r;
  logic started_r;
  logic msg_phase_r;
  pae_val_t prev_sp_r;
  logic [PAE_VAL_W-1:0] last_pv_r;

  logic alarm_type_select;
  logic latch_select;
  logic silence_select;
  logic block_select;
  assign alarm_type_select = ctrl_r[PAE_CTRL_TYPE_BIT];
  assign latch_select = ctrl_r[PAE_CTRL_LATCH_BIT];
  assign silence_select = ctrl_r[PAE_CTRL_SIL_BIT];
  assign block_select = ctrl_r[PAE_CTRL_BLOCK_BIT];

  // Thresholds, widened by one bit so offsets from the set point cannot wrap.
  logic signed [PAE_VAL_W:0] thr_hi;
  logic signed [PAE_VAL_W:0] thr_lo;
  logic signed [PAE_VAL_W:0] band_hi;
  logic signed [PAE_VAL_W:0] band_lo;
  logic signed [PAE_VAL_W:0] pv_x;
  logic signed [PAE_VAL_W:0] sp_x;
  logic signed [PAE_VAL_W:0] hi_x;
  logic signed [PAE_VAL_W:0] lo_x;
  logic signed [PAE_VAL_W:0] hy_x;
  logic signed [PAE_VAL_W:0] sh_x;
  logic signed [PAE_VAL_W:0] sl_x;
  assign sp_x = {control_setpoint[PAE_VAL_W-1], control_setpoint};
  assign hi_x = {high_alarm_setpoint_r[PAE_VAL_W-1], high_alarm_setpoint_r};
  assign lo_x = {low_alarm_setpoint_r[PAE_VAL_W-1], low_alarm_setpoint_r};
  assign hy_x = {hyst_r[PAE_VAL_W-1], hyst_r};
  assign sh_x = {sens_hi_r[PAE_VAL_W-1], sens_hi_r};
  assign sl_x = {sens_lo_r[PAE_VAL_W-1], sens_lo_r};
  always_comb
  begin
    if (alarm_type_select)
    begin
      thr_hi = sp_x + hi_x; // R3 R4
      thr_lo = sp_x - lo_x; // R3 R4
    end
    else
    begin
      thr_hi = hi_x; // R2
      thr_lo = lo_x; // R2
    end
    band_hi = thr_hi - hy_x; // R7
    band_lo = thr_lo + hy_x; // R7
    pv_x = {process_value[PAE_VAL_W-1], process_value};
  end

  logic hi_en;
  logic lo_en;
  logic trip;
  logic normal;
  logic cfg_bad;
  assign hi_en = ctrl_r[PAE_CTRL_HI_EN_BIT];
  assign lo_en = ctrl_r[PAE_CTRL_LO_EN_BIT];
  assign trip = (hi_en && pv_x >= thr_hi) || (lo_en && pv_x <= thr_lo); // R1 R6
  assign normal = !(hi_en && pv_x > band_hi) && !(lo_en && pv_x < band_lo); // R8
  assign cfg_bad = (hi_en && lo_en && thr_hi <= thr_lo) || (hi_en && thr_hi >= sh_x)
    || (lo_en && thr_lo <= sl_x); // R5

  logic sp_changed;
  assign sp_changed = alarm_type_select && (control_setpoint != prev_sp_r);

  // AXI4-Lite slave: one write and one read at a time.
  logic aw_done_r;
  logic w_done_r;
  pae_addr_t awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic wr_fire;
  assign s_axi_awready = !aw_done_r && !s_axi_bvalid;
  assign s_axi_wready = !w_done_r && !s_axi_bvalid;
  assign wr_fire = (aw_done_r || (s_axi_awvalid && s_axi_awready))
    && (w_done_r || (s_axi_wvalid && s_axi_wready));
  pae_addr_t wa;
  logic [31:0] wd;
  assign wa = aw_done_r ? awaddr_r : s_axi_awaddr;
  assign wd = w_done_r ? wdata_r : s_axi_wdata;
  logic wfull;
  assign wfull = (w_done_r ? wstrb_r : s_axi_wstrb) == 4'hF;
  logic wmap;
  assign wmap = wa <= PAE_IRQ_MASK_OFS && wa[1:0] == 2'h0 && wa != PAE_STATE_OFS;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      aw_done_r <= 1'b0;
      w_done_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PAE_RESP_OKAY;
    end
    else
    begin
      if (wr_fire)
      begin
        aw_done_r <= 1'b0;
        w_done_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wmap ? PAE_RESP_OKAY : PAE_RESP_SLVERR;
      end
      else
      begin
        if (s_axi_awvalid && s_axi_awready)
        begin
          aw_done_r <= 1'b1;
          awaddr_r <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready)
        begin
          w_done_r <= 1'b1;
          wdata_r <= s_axi_wdata;
          wstrb_r <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready)
          s_axi_bvalid <= 1'b0;
      end
    end
  end

  logic wr_ok;
  assign wr_ok = wr_fire && wmap && wfull;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ctrl_r <= PAE_CTRL_RST;
      high_alarm_setpoint_r <= PAE_HIGH_RST;
      low_alarm_setpoint_r <= PAE_LOW_RST;
      hyst_r <= PAE_HYST_RST;
      sens_hi_r <= PAE_SENS_HI_RST;
      sens_lo_r <= PAE_SENS_LO_RST;
      irq_mask_r <= '0;
    end
    else if (wr_ok)
    begin
      case (wa)
        PAE_CTRL_OFS: ctrl_r <= wd[PAE_CTRL_W-1:0];
        PAE_HIGH_OFS: high_alarm_setpoint_r <= wd[PAE_VAL_W-1:0];
        PAE_LOW_OFS: low_alarm_setpoint_r <= wd[PAE_VAL_W-1:0];
        PAE_HYST_OFS: hyst_r <= wd[PAE_VAL_W-1:0];
        PAE_SENS_HI_OFS: sens_hi_r <= wd[PAE_VAL_W-1:0];
        PAE_SENS_LO_OFS: sens_lo_r <= wd[PAE_VAL_W-1:0];
        PAE_IRQ_MASK_OFS: irq_mask_r <= wd[PAE_IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  logic sw_clear;
  logic sw_silence;
  assign sw_clear = wr_ok && wa == PAE_ACTION_OFS && wd[PAE_ACT_CLEAR_BIT];
  assign sw_silence = wr_ok && wa == PAE_ACTION_OFS && wd[PAE_ACT_SILENCE_BIT];
  logic clear_req;
  logic silence_req;
  assign clear_req = op_clear || sw_clear; // R16
  assign silence_req = op_silence || sw_silence;

  // Alarm state machine, advanced on each process value update.
  logic ev_raise;
  logic ev_end;
  logic ev_arm;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_r <= PAE_ST_IDLE;
      silenced_r <= 1'b0;
      blocked_r <= 1'b1;
      started_r <= 1'b0;
      prev_sp_r <= '0;
      last_pv_r <= '0;
      ev_raise <= 1'b0;
      ev_end <= 1'b0;
      ev_arm <= 1'b0;
    end
    else
    begin
      ev_raise <= 1'b0;
      ev_end <= 1'b0;
      ev_arm <= 1'b0;
      if (silence_req && silence_select && state_r != PAE_ST_IDLE)
        silenced_r <= 1'b1; // R11
      if (pv_valid) // R18
      begin
        last_pv_r <= process_value;
        prev_sp_r <= control_setpoint;
        started_r <= 1'b1;
        if (normal && silenced_r)
        begin
          silenced_r <= 1'b0; // R12
          ev_arm <= 1'b1;
        end
        if (block_select && (!started_r || sp_changed) && !normal)
          blocked_r <= 1'b1; // R13 R15
        else if (normal || !block_select)
          blocked_r <= 1'b0; // R14
        case (state_r)
          PAE_ST_IDLE:
          begin
            if (trip && !(block_select && (blocked_r || !started_r || sp_changed)))
            begin
              state_r <= PAE_ST_ALARM; // R1 R6
              ev_raise <= 1'b1;
            end
          end
          PAE_ST_ALARM:
          begin
            if (normal)
            begin
              state_r <= latch_select ? PAE_ST_HELD : PAE_ST_IDLE; // R9 R10
              ev_end <= 1'b1;
            end
          end
          PAE_ST_HELD:
          begin
            if (trip)
              state_r <= PAE_ST_ALARM;
          end
          default: state_r <= PAE_ST_IDLE;
        endcase
      end
      else if (clear_req && state_r == PAE_ST_HELD)
      begin
        state_r <= PAE_ST_IDLE; // R9 R16
        silenced_r <= 1'b0;
      end
    end
  end

  assign alarm_active = state_r != PAE_ST_IDLE; // R16
  assign alarm_output = alarm_active && !silenced_r; // R11

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      msg_phase_r <= 1'b0;
    else if (!alarm_active)
      msg_phase_r <= 1'b0;
    else if (display_tick)
      msg_phase_r <= !msg_phase_r; // R17
  end
  assign upper_show_message = msg_phase_r;
  assign attention_indicator = alarm_active; // R17

  // Sticky interrupt status; a set in the same cycle as a clear wins.
  logic [PAE_IRQ_W-1:0] irq_set;
  logic [PAE_IRQ_W-1:0] irq_clr;
  always_comb
  begin
    irq_set = '0;
    irq_set[PAE_IRQ_RAISE_BIT] = ev_raise;
    irq_set[PAE_IRQ_END_BIT] = ev_end;
    irq_set[PAE_IRQ_CFG_BIT] = cfg_bad; // R5
    irq_set[PAE_IRQ_ARM_BIT] = ev_arm;
    irq_clr = (wr_ok && wa == PAE_IRQ_STAT_OFS) ? wd[PAE_IRQ_W-1:0] : '0;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      irq_stat_r <= '0;
    else
      irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
  end
  assign irq = |(irq_stat_r & irq_mask_r);

  // Read channel.
  logic [31:0] rd_val;
  logic rd_map;
  always_comb
  begin
    rd_val = '0;
    rd_map = 1'b1;
    case (s_axi_araddr)
      PAE_CTRL_OFS: rd_val = {26'h0, ctrl_r};
      PAE_HIGH_OFS: rd_val = {16'h0, high_alarm_setpoint_r};
      PAE_LOW_OFS: rd_val = {16'h0, low_alarm_setpoint_r};
      PAE_HYST_OFS: rd_val = {16'h0, hyst_r};
      PAE_SENS_HI_OFS: rd_val = {16'h0, sens_hi_r};
      PAE_SENS_LO_OFS: rd_val = {16'h0, sens_lo_r};
      PAE_STATE_OFS: rd_val = {last_pv_r, 10'h0, blocked_r, silenced_r, alarm_output,
        cfg_bad, state_r};
      PAE_ACTION_OFS: rd_val = '0;
      PAE_IRQ_STAT_OFS: rd_val = {28'h0, irq_stat_r};
      PAE_IRQ_MASK_OFS: rd_val = {28'h0, irq_mask_r};
      default: rd_map = 1'b0;
    endcase
  end
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PAE_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_map ? PAE_RESP_OKAY : PAE_RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule
`default_nettype wire

// file: bench/pae_checker_assertions.sv
// Purpose: Port-level checks for the alarm evaluator.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Bound to pae_process_alarm_evaluator by the bind below.
`timescale 1ns/1ps
`default_nettype none
module pae_checker (
  input wire logic clk, // Clock.
  input wire logic resetn, // Reset, active low.
  input wire logic pv_valid, // Update strobe.
  input wire logic op_clear, // Clear pulse.
  input wire logic op_silence, // Silence pulse.
  input wire logic display_tick, // Toggle pulse.
  input wire logic s_axi_wvalid, // Write data valid.
  input wire logic alarm_active, // Alarm state.
  input wire logic alarm_output, // Output drive.
  input wire logic upper_show_message, // Upper display.
  input wire logic attention_indicator, // Attention.
  input wire logic irq // Interrupt.
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic wq1;
  logic wq2;
  // Register writes may act one or two edges after wvalid.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wq1 <= 1'b0;
      wq2 <= 1'b0;
    end
    else
    begin
      wq1 <= s_axi_wvalid;
      wq2 <= wq1;
    end
  end
  a_attn_mirror: assert property (attention_indicator == alarm_active)
    else $error("attention differs from alarm");
  a_out_needs_alarm: assert property (alarm_output |-> alarm_active)
    else $error("output without alarm");
  a_rise_on_update: assert property ($rose(alarm_active) |-> $past(pv_valid))
    else $error("alarm rose without update");
  a_fall_cause: assert property ($fell(alarm_active) |-> ($past(pv_valid)
    || $past(op_clear) || wq1 || wq2)) else $error("alarm fell without cause");
  a_msg_idle: assert property (!alarm_active && !$past(alarm_active)
    |-> !upper_show_message) else $error("message without alarm");
  a_msg_toggle: assert property (display_tick && alarm_active && !pv_valid && !op_clear
    && !s_axi_wvalid |=> upper_show_message != $past(upper_show_message))
    else $error("display did not toggle");
  a_irq_cause: assert property ($rose(irq) |-> ($past(pv_valid, 2) || $past(op_clear)
    || wq1 || wq2)) else $error("irq rose without cause");
  a_out_rearm: assert property ($rose(alarm_output) |-> ($past(pv_valid) || wq1 || wq2))
    else $error("output rose without update");
  a_out_drop: assert property ($fell(alarm_output) |-> ($past(pv_valid) || $past(op_clear)
    || $past(op_silence) || wq1 || wq2)) else $error("output fell without cause");
endmodule
bind pae_process_alarm_evaluator pae_checker u_chk (.clk(clk), .resetn(resetn),
  .pv_valid(pv_valid), .op_clear(op_clear), .op_silence(op_silence),
  .display_tick(display_tick), .s_axi_wvalid(s_axi_wvalid), .alarm_active(alarm_active),
  .alarm_output(alarm_output), .upper_show_message(upper_show_message),
  .attention_indicator(attention_indicator), .irq(irq));
`default_nettype wire

// file: bench/pae_panel_model.sv
// Purpose: Process value source and operator panel.
// Assumes: Driven by tasks called from the bench.
// Notes: The value line is scrambled outside its update strobe.
`timescale 1ns/1ps
`default_nettype none
module pae_panel_model (
  input wire logic clk, // Clock.
  output var pae_pkg::pae_val_t process_value, // Process value.
  output var logic pv_valid, // Update strobe.
  output var pae_pkg::pae_val_t control_setpoint, // Set point.
  output var logic op_clear, // Clear pulse.
  output var logic op_silence, // Silence pulse.
  output var logic display_tick // Toggle pulse.
);
  import pae_pkg::*;
  initial
  begin
    process_value = 16'h0000;
    pv_valid = 1'b0;
    control_setpoint = 16'h0000;
    op_clear = 1'b0;
    op_silence = 1'b0;
    display_tick = 1'b0;
  end
  task automatic update(input pae_val_t v);
    @(posedge clk);
    process_value <= v;
    pv_valid <= 1'b1;
    @(posedge clk);
    pv_valid <= 1'b0;
    process_value <= ~v;
    @(posedge clk);
  endtask
  task automatic set_sp(input pae_val_t v);
    @(posedge clk);
    control_setpoint <= v;
  endtask
  task automatic press(input int k);
    @(posedge clk);
    op_clear <= (k == 0);
    op_silence <= (k == 1);
    display_tick <= (k == 2);
    @(posedge clk);
    op_clear <= 1'b0;
    op_silence <= 1'b0;
    display_tick <= 1'b0;
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// Purpose: Self-checking bench for the alarm evaluator.
// Assumes: 20 MHz clock, register access over AXI4-Lite.
// Notes: Ends through results.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pae_pkg::*;
  logic clk, resetn, pv_valid, op_clear, op_silence, display_tick, m0;
  pae_val_t process_value, control_setpoint;
  pae_addr_t s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic alarm_active, alarm_output, upper_show_message, attention_indicator, irq;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  pae_panel_model pm (.clk(clk), .process_value(process_value), .pv_valid(pv_valid),
    .control_setpoint(control_setpoint), .op_clear(op_clear), .op_silence(op_silence),
    .display_tick(display_tick));
  pae_process_alarm_evaluator DUT (.clk(clk), .resetn(resetn), .process_value(process_value),
    .pv_valid(pv_valid), .control_setpoint(control_setpoint), .op_clear(op_clear),
    .op_silence(op_silence), .display_tick(display_tick), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .alarm_active(alarm_active), .alarm_output(alarm_output),
    .upper_show_message(upper_show_message), .attention_indicator(attention_indicator),
    .irq(irq));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic results;
    if (n_errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      n_errors++;
      results;
    end
  end
  task automatic chk1(input logic g, input logic e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %0t bit %b exp %b", $time, g, e);
    end
  endtask
  task automatic chkw(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e)
    begin
      n_errors++;
      $display("BAD %0t word %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input pae_addr_t a, input logic [31:0] d, input logic [1:0] er,
    input logic [3:0] s = 4'hF);
    logic pa, pw, ta, tw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw)
    begin
      @(negedge clk);
      ta = pa && s_axi_awready;
      tw = pw && s_axi_wready;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    chkw({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge clk);
    s_axi_bready <= 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input pae_addr_t a, input logic [31:0] m, input logic [31:0] e,
    input logic [1:0] er, input int rw = 0);
    logic t;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= (rw == 0);
    t = 1'b0;
    while (!t)
    begin
      @(negedge clk);
      t = s_axi_arready;
      @(posedge clk);
    end
    s_axi_arvalid <= 1'b0;
    repeat (rw) @(posedge clk);
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    chkw(s_axi_rdata & m, e);
    chkw({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  task automatic ev(input pae_val_t v, input logic ea, input logic eo);
    pm.update(v);
    @(negedge clk);
    chk1(alarm_active, ea);
    chk1(alarm_output, eo);
  endtask
  task automatic do_reset;
    @(posedge clk);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
  endtask
  initial
  begin
    resetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 6'h00;
    s_axi_araddr = 6'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    do_reset;
    rd(PAE_CTRL_OFS, 32'h3F, 32'h30, PAE_RESP_OKAY);
    wr(PAE_HIGH_OFS, 32'h1234, PAE_RESP_OKAY, 4'h3);
    rd(PAE_HIGH_OFS, 32'hFFFF, 32'h64, PAE_RESP_OKAY);
    rd(PAE_HYST_OFS, 32'hFFFF, 32'h1, PAE_RESP_OKAY, 3);
    rd(PAE_SENS_LO_OFS, 32'hFFFF, 32'h8000, PAE_RESP_OKAY);
    rd(6'h28, 32'hFFFFFFFF, 32'h0, PAE_RESP_SLVERR);
    wr(PAE_STATE_OFS, 32'h3, PAE_RESP_SLVERR);
    wr(PAE_HYST_OFS, 32'h5, PAE_RESP_OKAY);
    ev(16'sd50, 1'b0, 1'b0);
    ev(16'sd100, 1'b1, 1'b1);
    chk1(irq, 1'b0);
    wr(PAE_IRQ_MASK_OFS, 32'h1, PAE_RESP_OKAY);
    chk1(irq, 1'b1);
    wr(PAE_IRQ_STAT_OFS, 32'hF, PAE_RESP_OKAY);
    chk1(irq, 1'b0);
    ev(16'sd96, 1'b1, 1'b1);
    ev(16'sd95, 1'b0, 1'b0);
    ev(16'sd0, 1'b1, 1'b1);
    ev(16'sd4, 1'b1, 1'b1);
    ev(16'sd5, 1'b0, 1'b0);
    wr(PAE_CTRL_OFS, 32'h32, PAE_RESP_OKAY);
    ev(16'sd100, 1'b1, 1'b1);
    ev(16'sd50, 1'b1, 1'b1);
    rd(PAE_STATE_OFS, 32'h3, 32'h2, PAE_RESP_OKAY);
    pm.press(0);
    chk1(alarm_active, 1'b0);
    ev(16'sd100, 1'b1, 1'b1);
    ev(16'sd50, 1'b1, 1'b1);
    wr(PAE_ACTION_OFS, 32'h1, PAE_RESP_OKAY);
    chk1(alarm_active, 1'b0);
    wr(PAE_CTRL_OFS, 32'h34, PAE_RESP_OKAY);
    ev(16'sd100, 1'b1, 1'b1);
    pm.press(1);
    chk1(alarm_output, 1'b0);
    ev(16'sd96, 1'b1, 1'b0);
    ev(16'sd50, 1'b0, 1'b0);
    ev(16'sd100, 1'b1, 1'b1);
    m0 = upper_show_message;
    pm.press(2);
    chk1(upper_show_message, ~m0);
    ev(16'sd50, 1'b0, 1'b0);
    wr(PAE_CTRL_OFS, 32'h31, PAE_RESP_OKAY);
    wr(PAE_HIGH_OFS, 32'hA, PAE_RESP_OKAY);
    wr(PAE_LOW_OFS, 32'hA, PAE_RESP_OKAY);
    wr(PAE_HYST_OFS, 32'h1, PAE_RESP_OKAY);
    pm.set_sp(16'sd200);
    ev(16'sd205, 1'b0, 1'b0);
    ev(16'sd210, 1'b1, 1'b1);
    ev(16'sd200, 1'b0, 1'b0);
    pm.set_sp(16'sd300);
    ev(16'sd205, 1'b1, 1'b1);
    ev(16'sd300, 1'b0, 1'b0);
    do_reset;
    wr(PAE_CTRL_OFS, 32'h38, PAE_RESP_OKAY);
    ev(16'sd150, 1'b0, 1'b0);
    ev(16'sd50, 1'b0, 1'b0);
    ev(16'sd150, 1'b1, 1'b1);
    ev(16'sd50, 1'b0, 1'b0);
    wr(PAE_CTRL_OFS, 32'h39, PAE_RESP_OKAY);
    wr(PAE_HIGH_OFS, 32'hA, PAE_RESP_OKAY);
    wr(PAE_LOW_OFS, 32'hA, PAE_RESP_OKAY);
    pm.set_sp(16'sd50);
    ev(16'sd50, 1'b0, 1'b0);
    pm.set_sp(16'sd500);
    ev(16'sd50, 1'b0, 1'b0);
    ev(16'sd500, 1'b0, 1'b0);
    ev(16'sd520, 1'b1, 1'b1);
    results;
  end
endmodule
`default_nettype wire
